/* verilog/haptic_regs.vh */
`ifndef HAPTIC_REGS_VH
`define HAPTIC_REGS_VH

// Register offsets on the serial bus
`define REG_STATUS        8'h00
`define REG_MODE          8'h01
`define REG_PLAY_CFG      8'h07
`define REG_GO            8'h0C
`define REG_RT_AMPL       8'h0E
`define REG_SEQ_BASE      8'h0F
`define REG_SEQ_LAST      8'h16
`define REG_IMP_COEF      8'h30

// Field positions
`define MODE_FIELD_LSB    0
`define MODE_RUN          2'h0
`define MODE_CALIBRATE    2'h1
`define CFG_RT_SEL        0
`define CFG_TRIG_FN_LSB   2
`define CFG_CLOSED_LOOP   4
`define CFG_LIBRARY_SELECT_BIT       5
`define TRIG_FN_LEVEL     2'h0
`define TRIG_FN_EDGE      2'h1
`define TRIG_FN_INTR      2'h2

// Reset values
`define MODE_RESET        8'h0_3
`define CFG_RESET         8'h1_1
`define RT_AMPL_RESET     8'h7_f
`define SEQ_RESET         8'h0_0
`define IMP_COEF_RESET    8'h0_0
`define DEV_ADDR_DEFAULT  7'h5a

// Timing
`define STARTUP_TIME_US   500
`define CLK_MHZ           250
`define STARTUP_CYCLES    (`STARTUP_TIME_US * `CLK_MHZ)

`endif

/* verilog/haptic_playback_host_control.v */
// What this block does
// - Read-only 8-bit impedance coefficient at 0x30, reset zero, for software impedance math.
// - Writing zero to the mode field at address one leaves standby.
// - Reset defaults: closed loop, trigger pin level mode, real-time playback.
// - With trigger pin as interrupt, only the go bit starts or stops playback.
// - Every finished playback returns the device to standby by itself.
// - Real-time amplitude may be rewritten during playback; each new value applies.
// - Resonance tracking locks within half a cycle, retracks each cycle, no calibration.
// - Calibration adjusts drive level only, never the resonance tracker.
// - Without serial bus, pins alone play the default effect.
// - Both pins tied to supply: slow supply ramp gives undervoltage lockout, no playback.
// - Trigger pin edge or level starts the preloaded effect without bus traffic.
// - Trigger pin grounded: device runs only from register commands.
`timescale 1ns/1ps
`include "haptic_regs.vh"

module haptic_playback_host_control
#(
  parameter [6:0]  DEV_ADDR       = `DEV_ADDR_DEFAULT, // Arbitrary bus address
  parameter [31:0] STARTUP_CYCLES = `STARTUP_CYCLES
)
(
  input  wire       clk,
  input  wire       shutdown_release_pin,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe,
  input  wire       trig_i,
  output wire       trig_o,
  output wire       trig_oe,
  input  wire       supply_ok,
  input  wire       diag_done,
  input  wire [7:0] diag_coef,
  input  wire       effect_done,
  input  wire       calib_done,
  output reg  [7:0] effect_index,
  output reg        effect_start,
  output reg        rt_drive_en,
  output reg  [7:0] drive_amplitude,
  output reg        calib_start,
  output wire       closed_loop,
  output wire       library_select,
  output wire       resonance_track_en
);

  localparam [2:0] S_STARTUP = 3'd0, S_STANDBY = 3'd1, S_READY = 3'd2,
                   S_RT = 3'd3, S_SEQ = 3'd4, S_SEQ_WAIT = 3'd5, S_CAL = 3'd6, S_LOCK = 3'd7;
  localparam [2:0] I_IDLE = 3'd0, I_ADDR = 3'd1, I_AACK = 3'd2, I_WDAT = 3'd3,
                   I_WACK = 3'd4, I_RDAT = 3'd5, I_RACK = 3'd6;

  reg [1:0]  scl_sy_q, sda_sy_q, trig_sy_q, sup_sy_q;
  reg        scl_prev_q, sda_prev_q, trig_prev_q;
  reg [2:0]  i_st_q;
  reg [3:0]  bit_cnt_q;
  reg [7:0]  sh_q, ptr_q, rd_q;
  reg        rw_q, first_q, sda_oe_q;
  reg        wr_q;
  reg [7:0]  wr_addr_q, wr_data_q;
  reg [7:0]  mode_q, cfg_q, rt_ampl_q, imp_coef_q;
  reg [7:0]  seq_q [0:7];
  reg [2:0]  st_q, slot_q;
  reg [31:0] start_cnt_q;
  reg        done_flag_q, go_set_q, go_clr_q, status_rd_q;
  reg [7:0]  rd_mux;
  integer    k;

  wire scl_s  = scl_sy_q[1];
  wire sda_s  = sda_sy_q[1];
  wire trig_s = trig_sy_q[1];
  wire sup_s  = sup_sy_q[1];
  // Sequencer slot offsets; subtract at full width before slicing so 0x0F maps to slot 0
  wire [7:0] rd_slot = ptr_q - `REG_SEQ_BASE;
  wire [7:0] wr_slot = wr_addr_q - `REG_SEQ_BASE;
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire i_start  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire i_stop   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire [1:0] trig_fn = cfg_q[`CFG_TRIG_FN_LSB+1:`CFG_TRIG_FN_LSB];
  wire pin_live  = (trig_fn != `TRIG_FN_INTR) && (st_q != S_STARTUP);
  wire trig_rise = pin_live & trig_s & ~trig_prev_q;
  wire trig_fall = pin_live & ~trig_s & trig_prev_q;
  wire playing   = (st_q == S_RT) || (st_q == S_SEQ) || (st_q == S_SEQ_WAIT);

  // Pin start and stop events; interrupt mode masks the pin entirely
  wire pin_start = trig_rise;
  wire pin_stop  = (trig_fn == `TRIG_FN_LEVEL) ? trig_fall : trig_rise;
  wire do_start  = go_set_q | (pin_start & ~playing);
  wire do_stop   = go_clr_q | (pin_stop & playing);

  // Two-stage synchronisers; only the second stage feeds logic
  always @(posedge clk or negedge shutdown_release_pin)
  begin
    if (!shutdown_release_pin)
    begin
      scl_sy_q  <= 2'h3;
      sda_sy_q  <= 2'h3;
      trig_sy_q <= 2'h0;
      sup_sy_q  <= 2'h0;
    end
    else
    begin
      scl_sy_q  <= {scl_sy_q[0],  scl_i};
      sda_sy_q  <= {sda_sy_q[0],  sda_i};
      trig_sy_q <= {trig_sy_q[0], trig_i};
      sup_sy_q  <= {sup_sy_q[0],  supply_ok};
    end
  end

  // Readback mux; go reads as the live playback state
  always @*
  begin
    rd_mux = 8'h0_0;
    if (ptr_q == `REG_STATUS)
      rd_mux = {4'h0, done_flag_q, st_q == S_LOCK, playing, st_q == S_STANDBY};
    else if (ptr_q == `REG_MODE)
      rd_mux = mode_q;
    else if (ptr_q == `REG_PLAY_CFG)
      rd_mux = cfg_q;
    else if (ptr_q == `REG_GO)
      rd_mux = {7'h0, playing};
    else if (ptr_q == `REG_RT_AMPL)
      rd_mux = rt_ampl_q;
    else if (ptr_q >= `REG_SEQ_BASE && ptr_q <= `REG_SEQ_LAST)
      rd_mux = seq_q[rd_slot[2:0]];
    else if (ptr_q == `REG_IMP_COEF)
      rd_mux = imp_coef_q;
  end

  // Serial slave: sample on rising clock, shift and acknowledge on falling clock
  always @(posedge clk or negedge shutdown_release_pin)
  begin
    if (!shutdown_release_pin)
    begin
      scl_prev_q  <= 1'b1;
      sda_prev_q  <= 1'b1;
      i_st_q      <= I_IDLE;
      bit_cnt_q   <= 4'h0;
      sh_q        <= 8'h0_0;
      rd_q        <= 8'h0_0;
      ptr_q       <= 8'h0_0;
      rw_q        <= 1'b0;
      first_q     <= 1'b0;
      sda_oe_q    <= 1'b0;
      wr_q        <= 1'b0;
      wr_addr_q   <= 8'h0_0;
      wr_data_q   <= 8'h0_0;
      status_rd_q <= 1'b0;
    end
    else
    begin
      scl_prev_q  <= scl_s;
      sda_prev_q  <= sda_s;
      wr_q        <= 1'b0;
      status_rd_q <= 1'b0;
      if (i_start)
      begin
        i_st_q    <= I_ADDR;
        bit_cnt_q <= 4'h0;
        first_q   <= 1'b1;
        sda_oe_q  <= 1'b0;
      end
      else if (i_stop)
      begin
        i_st_q   <= I_IDLE;
        sda_oe_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (i_st_q == I_ADDR || i_st_q == I_WDAT || i_st_q == I_RDAT)
        begin
          sh_q      <= {sh_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        else if (i_st_q == I_RACK)
          rw_q <= ~sda_s; // Master ack keeps the read going
      end
      else if (scl_fall)
      begin
        case (i_st_q)
          I_ADDR:
            if (bit_cnt_q == 4'h8)
            begin
              if (sh_q[7:1] == DEV_ADDR)
              begin
                i_st_q   <= I_AACK;
                rw_q     <= sh_q[0];
                sda_oe_q <= 1'b1;
              end
              else
                i_st_q <= I_IDLE;
            end
          I_AACK:
          begin
            bit_cnt_q <= 4'h0;
            if (rw_q)
            begin
              i_st_q      <= I_RDAT;
              rd_q        <= {rd_mux[6:0], 1'b0};
              sda_oe_q    <= ~rd_mux[7];
              status_rd_q <= (ptr_q == `REG_STATUS);
            end
            else
            begin
              i_st_q   <= I_WDAT;
              sda_oe_q <= 1'b0;
            end
          end
          I_WDAT:
            if (bit_cnt_q == 4'h8)
            begin
              i_st_q   <= I_WACK;
              sda_oe_q <= 1'b1;
              first_q  <= 1'b0;
              if (first_q)
                ptr_q <= sh_q;
              else
              begin
                wr_q      <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= sh_q;
                ptr_q     <= ptr_q + 8'h0_1;
              end
            end
          I_WACK:
          begin
            i_st_q    <= I_WDAT;
            bit_cnt_q <= 4'h0;
            sda_oe_q  <= 1'b0;
          end
          I_RDAT:
            if (bit_cnt_q == 4'h8)
            begin
              i_st_q   <= I_RACK;
              sda_oe_q <= 1'b0;
              ptr_q    <= ptr_q + 8'h0_1;
            end
            else
            begin
              sda_oe_q <= ~rd_q[7];
              rd_q     <= {rd_q[6:0], 1'b0};
            end
          I_RACK:
            if (rw_q)
            begin
              i_st_q      <= I_RDAT;
              bit_cnt_q   <= 4'h0;
              rd_q        <= {rd_mux[6:0], 1'b0};
              sda_oe_q    <= ~rd_mux[7];
              status_rd_q <= (ptr_q == `REG_STATUS);
            end
            else
              i_st_q <= I_IDLE;
          default:
            i_st_q <= I_IDLE;
        endcase
      end
    end
  end

  // Register file writes; go is decoded into start and stop pulses
  always @(posedge clk or negedge shutdown_release_pin)
  begin
    if (!shutdown_release_pin)
    begin
      mode_q    <= `MODE_RESET;
      cfg_q     <= `CFG_RESET;
      rt_ampl_q <= `RT_AMPL_RESET;
      go_set_q  <= 1'b0;
      go_clr_q  <= 1'b0;
      for (k = 0; k < 8; k = k + 1)
        seq_q[k] <= `SEQ_RESET;
    end
    else
    begin
      go_set_q <= wr_q && wr_addr_q == `REG_GO && wr_data_q[0];
      go_clr_q <= wr_q && wr_addr_q == `REG_GO && !wr_data_q[0];
      if (wr_q)
      begin
        if (wr_addr_q == `REG_MODE)
          mode_q <= wr_data_q;
        else if (wr_addr_q == `REG_PLAY_CFG)
          cfg_q <= wr_data_q;
        else if (wr_addr_q == `REG_RT_AMPL)
          rt_ampl_q <= wr_data_q;
        else if (wr_addr_q >= `REG_SEQ_BASE && wr_addr_q <= `REG_SEQ_LAST)
          seq_q[wr_slot[2:0]] <= wr_data_q;
      end
    end
  end

  // Coefficient is loaded only by the diagnostic engine, never by the bus
  always @(posedge clk or negedge shutdown_release_pin)
  begin
    if (!shutdown_release_pin)
      imp_coef_q <= `IMP_COEF_RESET;
    else if (diag_done)
      imp_coef_q <= diag_coef;
  end

  // Playback sequencing; pins and go bit share one path
  always @(posedge clk or negedge shutdown_release_pin)
  begin
    if (!shutdown_release_pin)
    begin
      st_q         <= S_STARTUP;
      start_cnt_q  <= 32'h0000_0000;
      slot_q       <= 3'h0;
      trig_prev_q  <= 1'b0;
      done_flag_q  <= 1'b0;
      effect_index <= 8'h0_0;
      effect_start <= 1'b0;
      calib_start  <= 1'b0;
    end
    else
    begin
      effect_start <= 1'b0;
      calib_start  <= 1'b0;
      // Held low through startup so a pin already high counts as a rising edge
      if (st_q != S_STARTUP)
        trig_prev_q <= trig_s;
      if (status_rd_q)
        done_flag_q <= 1'b0;
      case (st_q)
        S_STARTUP:
          if (start_cnt_q >= STARTUP_CYCLES - 32'h0000_0001)
            st_q <= sup_s ? S_STANDBY : S_LOCK;
          else
            start_cnt_q <= start_cnt_q + 32'h0000_0001;
        S_LOCK:
          st_q <= S_LOCK;
        S_STANDBY, S_READY:
          if (wr_q && wr_addr_q == `REG_MODE &&
              wr_data_q[`MODE_FIELD_LSB+1:`MODE_FIELD_LSB] == `MODE_CALIBRATE)
          begin
            st_q        <= S_CAL;
            calib_start <= 1'b1;
          end
          else if (do_start && cfg_q[`CFG_RT_SEL])
            st_q <= S_RT;
          else if (do_start)
          begin
            st_q   <= S_SEQ;
            slot_q <= 3'h0;
          end
          else if (wr_q && wr_addr_q == `REG_MODE &&
                   wr_data_q[`MODE_FIELD_LSB+1:`MODE_FIELD_LSB] == `MODE_RUN)
            st_q <= S_READY;
        S_RT:
          if (do_stop)
          begin
            st_q        <= S_STANDBY;
            done_flag_q <= 1'b1;
          end
        S_SEQ:
          if (do_stop || seq_q[slot_q] == 8'h0_0)
          begin
            st_q        <= S_STANDBY;
            done_flag_q <= 1'b1;
          end
          else
          begin
            effect_index <= seq_q[slot_q];
            effect_start <= 1'b1;
            st_q         <= S_SEQ_WAIT;
          end
        S_SEQ_WAIT:
          if (do_stop || (effect_done && slot_q == 3'h7))
          begin
            st_q        <= S_STANDBY;
            done_flag_q <= 1'b1;
          end
          else if (effect_done)
          begin
            slot_q <= slot_q + 3'h1;
            st_q   <= S_SEQ;
          end
        S_CAL:
          if (calib_done)
          begin
            st_q        <= S_STANDBY;
            done_flag_q <= 1'b1;
          end
        default:
          st_q <= S_STANDBY;
      endcase
    end
  end

  // Amplitude follows the register every cycle so rewrites take effect at once
  always @(posedge clk or negedge shutdown_release_pin)
  begin
    if (!shutdown_release_pin)
    begin
      rt_drive_en     <= 1'b0;
      drive_amplitude <= 8'h0_0;
    end
    else
    begin
      rt_drive_en     <= (st_q == S_RT);
      drive_amplitude <= (st_q == S_RT) ? rt_ampl_q : 8'h0_0;
    end
  end

  // Tracker runs whenever closed-loop drive is active; calibration never gates it
  assign closed_loop        = cfg_q[`CFG_CLOSED_LOOP];
  assign library_select     = cfg_q[`CFG_LIBRARY_SELECT_BIT];
  assign resonance_track_en = closed_loop & playing;

  // Open-drain outputs: only ever pull low
  assign sda_o   = 1'b0;
  assign sda_oe  = sda_oe_q;
  assign trig_o  = 1'b0;
  assign trig_oe = (trig_fn == `TRIG_FN_INTR) & done_flag_q;

endmodule

/* bench/haptic_checker.sv */
`timescale 1ns/1ps
module haptic_checker
#(
  parameter [31:0] STARTUP_CYCLES = 32'h0000_0010
)
(
  input wire       clk,
  input wire       shutdown_release_pin,
  input wire       scl_i,
  input wire       sda_o,
  input wire       sda_oe,
  input wire       trig_o,
  input wire       effect_start,
  input wire       rt_drive_en,
  input wire [7:0] drive_amplitude,
  input wire       calib_start,
  input wire       closed_loop,
  input wire       library_select,
  input wire       resonance_track_en
);
  reg [31:0] boot_q;

  // Startup wait after each release; no playback may begin inside it
  always @(posedge clk or negedge shutdown_release_pin)
  begin
    if (!shutdown_release_pin)
      boot_q <= 32'h0000_0000;
    else if (boot_q < STARTUP_CYCLES)
      boot_q <= boot_q + 32'h0000_0001;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!shutdown_release_pin);

  // Output relations; each ties an output to its cause
  a_reset_defaults: assert property ($rose(shutdown_release_pin) |-> closed_loop && !library_select && !rt_drive_en)
    else $error("reset defaults wrong");
  a_startup_quiet: assert property (boot_q < STARTUP_CYCLES |-> !rt_drive_en && !effect_start)
    else $error("playback during startup");
  a_idle_amp: assert property (!rt_drive_en |-> drive_amplitude == 8'h00)
    else $error("amplitude without playback");
  a_track_loop: assert property (rt_drive_en |-> $past(resonance_track_en) == $past(closed_loop))
    else $error("tracking not following loop mode");
  a_track_open: assert property (resonance_track_en |-> closed_loop)
    else $error("tracking in open loop");
  a_calib_level: assert property (calib_start |-> !rt_drive_en && !resonance_track_en)
    else $error("calibration touched tracker");
  a_effect_single: assert property (effect_start |=> !effect_start)
    else $error("effect start longer than a pulse");
  a_rt_no_seq: assert property (rt_drive_en |-> !effect_start)
    else $error("two playbacks at once");
  a_ack_timing: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i, 2))
    else $error("data line changed with clock high");
  a_open_drain: assert property (sda_o == 1'b0 && trig_o == 1'b0)
    else $error("open drain pin driven high");

  c_rt: cover property ($rose(rt_drive_en));
  c_effect: cover property (effect_start);
  c_calib: cover property (calib_start);
  c_ack: cover property ($rose(sda_oe));
endmodule

bind haptic_playback_host_control haptic_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_i (
  .clk(clk), .shutdown_release_pin(shutdown_release_pin), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .trig_o(trig_o),
  .effect_start(effect_start), .rt_drive_en(rt_drive_en), .drive_amplitude(drive_amplitude),
  .calib_start(calib_start), .closed_loop(closed_loop), .library_select(library_select),
  .resonance_track_en(resonance_track_en));

/* bench/i2c_host_model.sv */
`timescale 1ns/1ps
`include "haptic_regs.vh"
module i2c_host_model
#(
  parameter H = 8
)
(
  input  wire clk,
  input  wire sda,
  output reg  scl = 1'b1,
  output reg  sda_low = 1'b0
);
  reg ok;

  // A third of a bit time, long against the device's input sync and ack delay
  task hp;
    repeat (H) @(posedge clk);
  endtask

  // One bit: data set while clock low, read back at the end of clock high
  task bt(input b, output r);
    sda_low <= ~b;
    hp;
    scl <= 1'b1;
    hp;
    r = sda;
    scl <= 1'b0;
    hp;
  endtask

  // Byte plus ninth bit; w marks a byte the device must acknowledge
  task xb(input [7:0] d, input w, output [7:0] q);
    integer i;
    reg     r;
    for (i = 7; i >= 0; i = i - 1)
    begin
      bt(d[i], r);
      q[i] = r;
    end
    bt(1'b1, r);
    if (w)
      ok = ok & ~r;
  endtask

  // Also a repeated start, since the clock rests low between bytes
  task start;
    sda_low <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    sda_low <= 1'b1;
    hp;
    scl <= 1'b0;
    hp;
  endtask

  task stop;
    sda_low <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    sda_low <= 1'b0;
    hp;
  endtask

  task wr(input [6:0] a, input [7:0] p, input [7:0] d);
    reg [7:0] q;
    ok = 1'b1;
    start;
    xb({a, 1'b0}, 1'b1, q);
    xb(p, 1'b1, q);
    xb(d, 1'b1, q);
    stop;
  endtask

  // Single byte read; the data byte is answered with no ack
  task rd(input [7:0] p, output [7:0] q);
    ok = 1'b1;
    start;
    xb({`DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q);
    xb(p, 1'b1, q);
    start;
    xb({`DEV_ADDR_DEFAULT, 1'b1}, 1'b1, q);
    xb(8'hff, 1'b0, q);
    stop;
  endtask
endmodule

/* bench/haptic_playback_host_control_tb_top.sv */
`timescale 1ns/1ps
`include "haptic_regs.vh"
module haptic_playback_host_control_tb_top;
  reg        clk = 1'b0, shutdown_release_pin = 1'b0, trig = 1'b0, supply_ok = 1'b1;
  reg        diag_done = 1'b0, effect_done = 1'b0, calib_done = 1'b0;
  reg  [7:0] diag_coef = 8'h00, q, last_idx = 8'h00;
  integer    n_errors = 0, num_checks = 0, n_eff = 0, n_cal = 0;
  wire       scl, sda_low, sda_oe, trig_oe, rt_drive_en, effect_start, calib_start;
  wire       closed_loop, library_select;
  wire [7:0] effect_index, drive_amplitude;
  // Open-drain lines with pull-ups: low while any party pulls
  wire       sda = ~(sda_low | sda_oe);
  wire       trig_pin = trig & ~trig_oe;

  always #2 clk = ~clk;

  // Short startup count keeps the run brief
  haptic_playback_host_control #(.STARTUP_CYCLES(32'h0000_0010)) dut (
    .clk(clk), .shutdown_release_pin(shutdown_release_pin), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .trig_i(trig_pin), .trig_o(), .trig_oe(trig_oe), .supply_ok(supply_ok),
    .diag_done(diag_done), .diag_coef(diag_coef), .effect_done(effect_done),
    .calib_done(calib_done), .effect_index(effect_index), .effect_start(effect_start),
    .rt_drive_en(rt_drive_en), .drive_amplitude(drive_amplitude), .calib_start(calib_start),
    .closed_loop(closed_loop), .library_select(library_select), .resonance_track_en());

  i2c_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  // Pulses are short, so they are counted here rather than polled
  always @(posedge clk)
  begin
    if (effect_start)
    begin
      n_eff <= n_eff + 1;
      last_idx <= effect_index;
    end
    if (calib_start)
      n_cal <= n_cal + 1;
  end

  task end_of_test;
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask

  task chk(input string nm, input [7:0] e, input [7:0] g);
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    host.wr(`DEV_ADDR_DEFAULT, a, d);
    chk("ack", 8'h01, 8'(host.ok));
  endtask

  task rd(input [7:0] a, input [7:0] e, input string nm);
    host.rd(a, q);
    chk("ack", 8'h01, 8'(host.ok));
    chk(nm, e, q);
  endtask

  // One-cycle pulse: 0 diagnostic, 1 calibration, 2 effect finished
  task pulse(input integer k);
    diag_done <= (k == 0);
    calib_done <= (k == 1);
    effect_done <= (k == 2);
    tick(1);
    diag_done <= 1'b0;
    calib_done <= 1'b0;
    effect_done <= 1'b0;
    tick(1);
  endtask

  function logic sig(input integer k);
    sig = (k == 0) ? rt_drive_en : trig_oe;
  endfunction

  // Bounded wait on a level; a hang ends the run
  task wt(input integer k, input v);
    integer i;
    for (i = 0; i < 400 && sig(k) !== v; i = i + 1)
      @(negedge clk);
    chk("wait level", 8'(v), 8'(sig(k)));
    if (sig(k) !== v)
      end_of_test;
    tick(2);
  endtask

  task rst(input s, input t);
    shutdown_release_pin <= 1'b0;
    supply_ok <= s;
    trig <= t;
    tick(3);
    shutdown_release_pin <= 1'b1;
    tick(40);
  endtask

  initial
  begin
    tick(3);
    shutdown_release_pin <= 1'b1;
    tick(40);
    chk("closed_loop", 8'h01, 8'(closed_loop));
    chk("library_select", 8'h00, 8'(library_select));
    rd(`REG_PLAY_CFG, 8'h11, "cfg");
    wr(`REG_IMP_COEF, 8'h55);
    rd(`REG_IMP_COEF, 8'h00, "coef");
    diag_coef <= 8'ha5;
    pulse(0);
    rd(`REG_IMP_COEF, 8'ha5, "coef");
    rd(8'h40, 8'h00, "unmapped");
    host.wr(7'h11, `REG_MODE, 8'h00);
    chk("ack", 8'h00, 8'(host.ok));
    wr(`REG_MODE, 8'h00);
    rd(`REG_STATUS, 8'h00, "status");
    wr(`REG_MODE, 8'h01);
    pulse(1);
    chk("calib", 8'h01, n_cal[7:0]);
    // Level trigger with amplitude rewritten mid-playback
    wr(`REG_RT_AMPL, 8'h40);
    trig <= 1'b1;
    wt(0, 1'b1);
    chk("amp", 8'h40, drive_amplitude);
    wr(`REG_RT_AMPL, 8'h90);
    chk("amp", 8'h90, drive_amplitude);
    trig <= 1'b0;
    wt(0, 1'b0);
    rd(`REG_STATUS, 8'h09, "status");
    rd(`REG_STATUS, 8'h01, "status");
    // Interrupt mode: pin ignored, go bit only
    wr(`REG_PLAY_CFG, 8'h19);
    trig <= 1'b1;
    tick(30);
    chk("rt_drive_en", 8'h00, 8'(rt_drive_en));
    wr(`REG_GO, 8'h01);
    wt(0, 1'b1);
    wr(`REG_GO, 8'h00);
    wt(0, 1'b0);
    wt(1, 1'b1);
    rd(`REG_STATUS, 8'h09, "status");
    wt(1, 1'b0);
    // Library sequence started by a rising edge
    trig <= 1'b0;
    wr(`REG_PLAY_CFG, 8'h34);
    chk("library_select", 8'h01, 8'(library_select));
    wr(`REG_SEQ_BASE, 8'h03);
    wr(8'h10, 8'h07);
    trig <= 1'b1;
    tick(20);
    chk("first index", 8'h03, last_idx);
    pulse(2);
    tick(10);
    chk("next index", 8'h07, last_idx);
    chk("effects", 8'h02, n_eff[7:0]);
    pulse(2);
    tick(10);
    rd(`REG_STATUS, 8'h09, "status");
    // Edge mode real-time: a falling pin is ignored, only the next rising edge stops
    wr(`REG_PLAY_CFG, 8'h15);
    trig <= 1'b0;
    tick(10);
    trig <= 1'b1;
    wt(0, 1'b1);
    trig <= 1'b0;
    tick(20);
    chk("rt_drive_en", 8'h01, 8'(rt_drive_en));
    trig <= 1'b1;
    wt(0, 1'b0);
    // Pins tied high: bad supply locks out, good supply plays
    rst(1'b0, 1'b1);
    chk("rt_drive_en", 8'h00, 8'(rt_drive_en));
    rd(`REG_STATUS, 8'h04, "status");
    rst(1'b1, 1'b1);
    wt(0, 1'b1);
    trig <= 1'b0;
    wt(0, 1'b0);
    end_of_test;
  end
endmodule
